/* File: dv/qdb_host_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Bus control module stand-in: runs one addressed byte cycle per call
module qdb_host_model (
   input  wire logic                       i_mclk,
   input  wire logic                       i_reply,
   input  wire logic                       i_selected,
   input  wire logic                       i_data_oe,
   input  wire logic [qdb_pkg::BYTE_W-1:0] i_data,
   output qdb_pkg::qdb_bus_s               o_bus
);
   initial o_bus = '0;

   // Write (rd=0) or read (rd=1); ok stays low if no reply came in 20 cycles
   task automatic cycle(input logic rd, input logic [15:0] adr, input logic [7:0] wd,
                        output logic ok, output logic [7:0] rdat, output int lat, output logic sel);
      ok = 1'b0;
      sel = 1'b0;
      rdat = '0;
      lat = 0;
      @(posedge i_mclk);
      o_bus.addr <= adr;
      // A released data line shows the inverse, never the stale byte
      o_bus.data <= rd ? ~o_bus.data : wd;
      @(posedge i_mclk);
      o_bus.addr_valid <= 1'b1;
      @(posedge i_mclk);
      o_bus.read_cycle <= rd;
      o_bus.write_cycle <= !rd;
      for (int n = 0; n < 20 && !ok; n++)
      begin
         @(posedge i_mclk);
         // Selection stands from the address phase to the end of the cycle
         if (i_selected === 1'b1)
            sel = 1'b1;
         if (i_reply === 1'b1)
         begin
            ok = 1'b1;
            rdat = i_data;
         end
         else if (i_data_oe === 1'b1)
            lat++;
      end
      // Strobes drop once the reply was taken or the 20 cycles ran out
      o_bus.read_cycle <= 1'b0;
      o_bus.write_cycle <= 1'b0;
      o_bus.addr_valid <= 1'b0;
      o_bus.data <= ~o_bus.data;
      // Gap so the next cycle gives a fresh address-valid edge
      repeat (6) @(posedge i_mclk);
   endtask
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ns
module testbench;
   localparam logic [7:0]  ID_VAL = 8'hC3;    // Arbitrary identification value
   localparam logic [12:0] BASE   = 13'h1E56;
   logic                   i_mclk;
   logic                   i_reset;
   qdb_pkg::qdb_bus_s      bus;
   qdb_pkg::qdb_ctl_s      ctl;
   logic [3:0]             range_off;
   logic [7:0]             rdata;
   logic                   oe;
   logic                   reply;
   logic                   selected;
   logic [3:0][9:0]        dac_code;
   logic [3:0][13:0]       volt;
   logic [3:0][24:0]       cur;
   logic [3:0]             cmp;
   logic [3:0][9:0]        model;
   int                     n_fail;
   int                     checked;

   qdb_quad_dac #(.ID_CODE(ID_VAL)) qdb_quad_dac_inst (.i_mclk(i_mclk), .i_reset(i_reset), .i_bus(bus),
      .i_base_addr(BASE), .i_ctl(ctl), .i_range_offset(range_off), .o_data(rdata), .o_data_oe(oe),
      .o_cycle_reply(reply), .o_module_selected(selected), .o_dac_code(dac_code), .o_volt_mv(volt),
      .o_current_na(cur), .o_cmp_status(cmp));
   qdb_host_model qdb_host_model_inst (.i_mclk(i_mclk), .i_reply(reply), .i_data_oe(oe), .i_data(rdata),
      .i_selected(selected), .o_bus(bus));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, watchdog and shared helpers
   initial
   begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   // Whole run needs well under 20000 cycles; a hang ends here
   initial
   begin
      repeat (20000) @(posedge i_mclk);
      n_fail++;
      give_verdict();
   end

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // One byte write; a refused cycle must get no reply
   task automatic wr(input logic [2:0] sel, input logic [7:0] d, input logic exp_ok);
      logic ok;
      logic [7:0] r;
      int lat;
      logic s;
      qdb_host_model_inst.cycle(1'b0, {BASE ^ {12'h0, !exp_ok}, sel}, d, ok, r, lat, s);
      chk("write reply", exp_ok, ok);                            // Write handshake
      chk("write selected", exp_ok, s);                          // Selection
   endtask

   // One byte read, checked for data and for drive time before the reply
   task automatic rd(input logic [2:0] sel, input logic [7:0] exp);
      logic ok;
      logic [7:0] r;
      int lat;
      logic s;
      qdb_host_model_inst.cycle(1'b1, {BASE, sel}, 8'h00, ok, r, lat, s);
      chk("read reply", 1'b1, ok);                               // Read handshake
      chk("read selected", 1'b1, s);                             // Selection
      chk("read byte", exp, r);                                  // Readback mux
      chk("drive before reply", qdb_pkg::READ_DELAY_CYC, lat);    // Reply delay
   endtask

   // Full channel load, high byte first, then the low byte that commits the word
   task automatic load(input logic [1:0] ch, input logic [9:0] code);
      wr({ch, 1'b1}, {6'h00, code[9:8]}, 1'b1);                   // High byte first
      chk("code after high", model[ch], dac_code[ch]);           // Holding only
      wr({ch, 1'b0}, code[7:0], 1'b1);                            // Low byte loads
      model[ch] = code;
   endtask

   task automatic chk_out(input logic zero);
      logic [9:0] c;
      for (int k = 0; k < 4; k++)
      begin
         c = zero ? 10'h000 : model[k];
         chk("dac code", c, dac_code[k]);                          // Forced zero
         chk("volt mv", c * qdb_pkg::VOLT_LSB_MV, volt[k]);        // Voltage weight
         chk("current na", range_off[k] ? qdb_pkg::CUR4_BASE_NA + c * qdb_pkg::CUR4_STEP_NA
            : c * qdb_pkg::CUR0_STEP_NA, cur[k]);                  // Current weight
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_load();
      logic [9:0] codes [4] = '{10'h3FF, 10'h000, 10'h2AA, 10'h155};
      for (int k = 0; k < 4; k++)
         load(2'(k), codes[k]);
      repeat (4) @(posedge i_mclk);
      chk_out(1'b0);                                             // Loaded outputs
      for (int k = 0; k < 4; k++)
      begin
         rd({2'(k), 1'b1}, {6'h00, codes[k][9:8]});                // High byte
         rd({2'(k), 1'b0}, codes[k][7:0]);                         // Low byte
      end
   endtask

   // High byte alone leaves output and readback untouched, until the low byte
   task automatic t_hold();
      wr(3'h5, 8'h01, 1'b1);                                      // Held only
      repeat (4) @(posedge i_mclk);
      chk_out(1'b0);                                             // Unchanged
      rd(3'h5, {6'h00, model[2][9:8]});                           // Register readback
      wr(3'h4, 8'h0F, 1'b1);                                      // Joined word
      model[2] = 10'h10F;
      repeat (4) @(posedge i_mclk);
      chk_out(1'b0);                                             // New code
   endtask

   // Foreign address: no reply and nothing stored
   task automatic t_refuse();
      wr(3'h0, 8'h55, 1'b0);                                      // Not selected
      repeat (4) @(posedge i_mclk);
      chk_out(1'b0);                                             // No strobe
   endtask

   task automatic t_zero();
      ctl.output_zero_ctl <= 1'b1;
      repeat (8) @(posedge i_mclk);
      chk_out(1'b1);                                             // All zero
      rd(3'h0, model[0][7:0]);                                    // Registers kept
      ctl.output_zero_ctl <= 1'b0;
      repeat (8) @(posedge i_mclk);
      chk_out(1'b0);                                             // Restored
   endtask

   task automatic t_ident();
      ctl.ident_select <= 1'b1;
      repeat (6) @(posedge i_mclk);
      rd(3'h3, ID_VAL);                                           // Identification
      rd(3'h6, ID_VAL);                                           // Identification
      ctl.ident_select <= 1'b0;
      repeat (6) @(posedge i_mclk);
      rd(3'h6, model[3][7:0]);                                    // Normal data again
   endtask

   // Two code sets well outside the comparator band; zeroing stays off here
   task automatic t_diag();
      logic [3:0] exp [2] = '{4'hD, 4'h2};
      for (int p = 0; p < 2; p++)
      begin
         for (int k = 0; k < 4; k++)
            load(2'(k), ((k % 2) == p) ? 10'h000 : 10'h3FF);
         ctl.diag_status_enable <= 1'b1;
         repeat (8) @(posedge i_mclk);
         chk("cmp status", exp[p], cmp);                           // Channel pairs
         rd(3'h3, {2'b00, exp[p], model[1][9:8]});                 // Status field
         ctl.diag_status_enable <= 1'b0;
         repeat (6) @(posedge i_mclk);
         rd(3'h1, {6'h00, model[0][9:8]});                         // Status cleared
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      n_fail = 0;
      checked = 0;
      model = '0;
      ctl = '0;
      range_off = 4'hA;
      i_reset = 1'b1;
      repeat (3) @(posedge i_mclk);
      i_reset <= 1'b0;
      @(posedge i_mclk);
      chk("reply after reset", 1'b0, reply);
      t_load();
      t_hold();
      t_refuse();
      t_zero();
      t_ident();
      t_diag();
      give_verdict();
   end
endmodule

/* File: hdl/qdb_quad_dac.sv */
// Overview of operation
// - Address match on address-valid raises module selected
// - Latch low three address bits for cycle
// - Write strobe raises exactly one byte strobe
// - Write strobe produces the cycle reply
// - High byte fills holding register only
// - Low byte loads ten-bit output register
// - Output register changes only on low write
// - Read drives selected byte onto data lines
// - Reply follows read drive after short delay
// - Ident select returns fixed identification code
// - Zero control forces all converter codes zero
// - Zeroed outputs keep registers, still readable
// - Diagnostic mode inserts status into high byte
// - Voltage weighting ten mV per step
// - Zero-based current 19.55 uA per step
// - Offset current 4 mA plus 15.64 uA steps
// - Status bits compare channel pairs, 30 mV margin
// - Status undefined inside the comparator band
// - Four channels, two byte addresses each
// - Code MSBs in D0-D1 of high byte
// - Status bits at D2-D5, top bits unused
`timescale 1ns/1ns
module qdb_quad_dac #(
   parameter logic [qdb_pkg::BYTE_W-1:0] ID_CODE = 8'h5A // Arbitrary value
) (
   input  wire logic                                            i_mclk,
   input  wire logic                                            i_reset,
   input  wire qdb_pkg::qdb_bus_s                               i_bus,
   input  wire logic [qdb_pkg::ADDR_W-1:qdb_pkg::SEL_W]         i_base_addr,
   input  wire qdb_pkg::qdb_ctl_s                               i_ctl,
   input  wire logic [qdb_pkg::NUM_CH-1:0]                      i_range_offset,
   output logic      [qdb_pkg::BYTE_W-1:0]                      o_data,
   output logic                                                 o_data_oe,
   output logic                                                 o_cycle_reply,
   output logic                                                 o_module_selected,
   output logic      [qdb_pkg::NUM_CH-1:0][qdb_pkg::CODE_W-1:0] o_dac_code,
   output logic      [qdb_pkg::NUM_CH-1:0][qdb_pkg::MV_W-1:0]   o_volt_mv,
   output logic      [qdb_pkg::NUM_CH-1:0][qdb_pkg::NA_W-1:0]   o_current_na,
   output logic      [qdb_pkg::STAT_W-1:0]                      o_cmp_status
);

   localparam int CFG_W = qdb_pkg::ADDR_W - qdb_pkg::SEL_W + qdb_pkg::NUM_CH;

   qdb_pkg::qdb_state_s                                st;
   qdb_pkg::qdb_state_s                                next;
   qdb_pkg::qdb_bus_s                                  bus;
   qdb_pkg::qdb_ctl_s                                  ctl;
   logic [qdb_pkg::ADDR_W-1:qdb_pkg::SEL_W]            base;
   logic [qdb_pkg::NUM_CH-1:0]                         range_offset;
   logic [qdb_pkg::BYTE_W-1:0]                         byte_write_strobes;
   logic [qdb_pkg::BYTE_W-1:0]                         rd_mux;
   logic [qdb_pkg::STAT_W-1:0]                         cmp_above;
   logic [qdb_pkg::STAT_W-1:0]                         cmp_below;
   logic                                               av_rise;
   logic [1:0]                                         rd_ch;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   // Strobes, address and data all pass the same two stages, so data set
   // up before a strobe on the pins is still ahead of it after the flops
   qdb_sync #(.W($bits(qdb_pkg::qdb_bus_s))) u_sync_bus (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_d     (i_bus),
      .o_q     (bus)
   );

   qdb_sync #(.W($bits(qdb_pkg::qdb_ctl_s))) u_sync_ctl (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_d     (i_ctl),
      .o_q     (ctl)
   );

   // Address switches and range switches are static straps
   qdb_sync #(.W(CFG_W)) u_sync_cfg (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_d     ({i_base_addr, i_range_offset}),
      .o_q     ({base, range_offset})
   );

   ////////////////////////////////////////////////////////////////////////////
   // Analog model and comparator network

   generate
      for (genvar ch = 0; ch < qdb_pkg::NUM_CH; ch++)
      begin : g_chan
         qdb_scale u_scale (
            .i_mclk         (i_mclk),
            .i_reset        (i_reset),
            .i_code         (st.dac[ch]),
            .i_range_offset (range_offset[ch]),
            .o_mv           (o_volt_mv[ch]),
            .o_na           (o_current_na[ch])
         );
      end
      for (genvar k = 0; k < qdb_pkg::STAT_W; k++)
      begin : g_cmp
         logic [qdb_pkg::MV_W:0] va;
         logic [qdb_pkg::MV_W:0] vb;
         assign va = {1'b0, o_volt_mv[qdb_pkg::CMP_A[k]]};
         assign vb = {1'b0, o_volt_mv[qdb_pkg::CMP_B[k]]};
         // Strictly above by the margin reads one, at or below by it reads zero
         assign cmp_above[k] = va > vb + (qdb_pkg::MV_W+1)'(qdb_pkg::CMP_MARGIN_MV);
         assign cmp_below[k] = va + (qdb_pkg::MV_W+1)'(qdb_pkg::CMP_MARGIN_MV) <= vb;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Readback multiplexer

   // Readback comes from the output registers, not the zeroed codes
   always_comb
   begin
      rd_ch = st.reg_sel[qdb_pkg::SEL_W-1:1];
      rd_mux = '0;
      if (ctl.ident_select)
         rd_mux = ID_CODE;
      else if (st.reg_sel[0])
      begin
         rd_mux[qdb_pkg::HI_CODE_LSB +: qdb_pkg::HI_W] =
            st.outreg[rd_ch][qdb_pkg::CODE_W-1 -: qdb_pkg::HI_W];
         if (ctl.diag_status_enable)
            rd_mux[qdb_pkg::STAT_LSB +: qdb_pkg::STAT_W] = st.cmp;
      end
      else
         rd_mux = st.outreg[rd_ch][qdb_pkg::BYTE_W-1:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus cycle sequencer and data registers

   always_comb
   begin
      next = st;
      byte_write_strobes = '0;
      av_rise = bus.addr_valid & ~st.av_prev;
      next.av_prev = bus.addr_valid;

      // Selection is decided once per cycle, on the address-valid edge
      if (av_rise)
      begin
         next.module_selected = (bus.addr[qdb_pkg::ADDR_W-1:qdb_pkg::SEL_W] == base);
         next.reg_sel = bus.addr[qdb_pkg::SEL_W-1:0];
      end
      else if (!bus.addr_valid)
         next.module_selected = 1'b0;

      unique case (st.phase)
         qdb_pkg::PH_IDLE:
         begin
            if (st.module_selected && bus.write_cycle)
            begin
               byte_write_strobes = qdb_pkg::BYTE_W'(1) << st.reg_sel;
               next.reply = 1'b1;
               next.phase = qdb_pkg::PH_WRITE;
            end
            else if (st.module_selected && bus.read_cycle)
            begin
               next.drive = 1'b1;
               next.rdata = rd_mux;
               next.cnt = qdb_pkg::READ_CYC;
               next.phase = qdb_pkg::PH_READ_WAIT;
            end
         end
         qdb_pkg::PH_WRITE:
         begin
            // One strobe per cycle; a new one needs the strobe or address-valid to drop first
            if (!bus.write_cycle || !bus.addr_valid)
            begin
               next.reply = 1'b0;
               next.phase = qdb_pkg::PH_IDLE;
            end
         end
         qdb_pkg::PH_READ_WAIT:
         begin
            next.rdata = rd_mux;
            if (!bus.read_cycle || !bus.addr_valid)
            begin
               next.drive = 1'b0;
               next.phase = qdb_pkg::PH_IDLE;
            end
            else if (st.cnt == 4'h1)
            begin
               next.reply = 1'b1;
               next.phase = qdb_pkg::PH_READ_DONE;
            end
            else
               next.cnt = st.cnt - 4'h1;
         end
         qdb_pkg::PH_READ_DONE:
         begin
            next.rdata = rd_mux;
            if (!bus.read_cycle || !bus.addr_valid)
            begin
               next.drive = 1'b0;
               next.reply = 1'b0;
               next.phase = qdb_pkg::PH_IDLE;
            end
         end
      endcase

      // Odd address fills the holding bits, even address commits all ten
      for (int ch = 0; ch < qdb_pkg::NUM_CH; ch++)
      begin
         if (byte_write_strobes[2*ch+1])
            next.hold[ch] = bus.data[qdb_pkg::HI_W-1:0];
         if (byte_write_strobes[2*ch])
            next.outreg[ch] = {st.hold[ch], bus.data};
         // Zeroing gates the converter input only; outreg is untouched
         next.dac[ch] = ctl.output_zero_ctl ? '0 : st.outreg[ch];
      end

      // Inside the band the previous value stays; it carries no meaning there
      for (int k = 0; k < qdb_pkg::STAT_W; k++)
      begin
         if (cmp_above[k])
            next.cmp[k] = 1'b1;
         else if (cmp_below[k])
            next.cmp[k] = 1'b0;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         st <= '0;
         st.phase <= qdb_pkg::PH_IDLE;
      end
      else
         st <= next;
   end

   // Outputs straight from state flops
   assign o_data            = st.rdata;
   assign o_data_oe         = st.drive;
   assign o_cycle_reply     = st.reply;
   assign o_module_selected = st.module_selected;
   assign o_dac_code        = st.dac;
   assign o_cmp_status      = st.cmp;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_reset);

   a_select_on_match: assert property (
      (av_rise && bus.addr[qdb_pkg::ADDR_W-1:qdb_pkg::SEL_W] == base) |=> o_module_selected)
      else $error("module not selected on matching address");

   a_sel_bits_hold: assert property (
      (bus.addr_valid && st.av_prev) |=> $stable(st.reg_sel))
      else $error("register select changed inside a cycle");

   a_one_byte_strobe: assert property (
      (|byte_write_strobes) |-> ($onehot(byte_write_strobes) && byte_write_strobes[st.reg_sel]))
      else $error("byte strobe not one-hot or wrong select");

   a_write_reply: assert property (
      (|byte_write_strobes) |=> o_cycle_reply [*1] ##0 !o_data_oe)
      else $error("no reply after write strobe");

   a_high_keeps_out: assert property (
      (|(byte_write_strobes & 8'hAA)) |=> $stable(st.outreg) && $changed(st.hold) || $stable(st.outreg))
      else $error("high byte write changed output register");

   a_low_loads_word: assert property (
      byte_write_strobes[0] |=> st.outreg[0] == {$past(st.hold[0]), $past(bus.data)})
      else $error("low byte write did not load ten-bit word");

   a_out_only_low: assert property (
      !(|(byte_write_strobes & 8'h55)) |=> $stable(st.outreg))
      else $error("output register changed without low byte write");

   a_read_delay: assert property (
      (st.phase == qdb_pkg::PH_IDLE && next.phase == qdb_pkg::PH_READ_WAIT)
         |=> (o_data_oe && !o_cycle_reply) [*5])
      else $error("read reply came before the drive delay");

   a_read_reply_due: assert property (
      (st.phase == qdb_pkg::PH_READ_WAIT && st.cnt == 4'h1 && bus.read_cycle && bus.addr_valid)
         |=> (o_cycle_reply && o_data_oe))
      else $error("read reply missing after delay");

   a_ident_read: assert property (
      (st.phase == qdb_pkg::PH_IDLE && next.phase == qdb_pkg::PH_READ_WAIT && ctl.ident_select)
         |=> o_data == ID_CODE)
      else $error("identification code not returned");

   a_zero_forces: assert property (
      ctl.output_zero_ctl |=> (o_dac_code == '0))
      else $error("converter code not zeroed");

   a_zero_readback: assert property (
      (next.phase == qdb_pkg::PH_READ_WAIT && st.phase == qdb_pkg::PH_IDLE
         && !ctl.ident_select && !st.reg_sel[0])
         |=> o_data == $past(st.outreg[st.reg_sel[2:1]][qdb_pkg::BYTE_W-1:0]))
      else $error("low byte readback wrong");

   a_high_byte_form: assert property (
      (next.phase == qdb_pkg::PH_READ_WAIT && st.phase == qdb_pkg::PH_IDLE
         && !ctl.ident_select && st.reg_sel[0])
         |=> o_data[7:6] == 2'h0 && (o_data[5:2] == ($past(ctl.diag_status_enable) ? $past(st.cmp) : 4'h0)))
      else $error("high byte status field wrong");

endmodule

/* File: hdl/qdb_scale.sv */
`timescale 1ns/1ns
module qdb_scale (
   input  wire logic                          i_mclk,
   input  wire logic                          i_reset,
   input  wire logic [qdb_pkg::CODE_W-1:0]    i_code,
   input  wire logic                          i_range_offset,
   output logic      [qdb_pkg::MV_W-1:0]      o_mv,
   output logic      [qdb_pkg::NA_W-1:0]      o_na
);

   logic [qdb_pkg::MV_W-1:0] next_mv;
   logic [qdb_pkg::NA_W-1:0] next_na;

   // Unsigned binary code, each bit weighted 2^n steps
   always_comb
   begin
      next_mv = qdb_pkg::MV_W'(i_code * qdb_pkg::VOLT_LSB_MV);
      if (i_range_offset)
         next_na = qdb_pkg::NA_W'(qdb_pkg::CUR4_BASE_NA + i_code * qdb_pkg::CUR4_STEP_NA);
      else
         next_na = qdb_pkg::NA_W'(i_code * qdb_pkg::CUR0_STEP_NA);
   end

   // Range selection only reaches the current path, never the code
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         o_mv <= '0;
         o_na <= '0;
      end
      else
      begin
         o_mv <= next_mv;
         o_na <= next_na;
      end
   end

endmodule

/* File: hdl/qdb_sync.sv */
`timescale 1ns/1ns
module qdb_sync #(
   parameter int W = 1
) (
   input  wire logic         i_mclk,
   input  wire logic         i_reset,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   logic [W-1:0] stage1;

   // Two flops; only the second stage is read outside
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         stage1 <= '0;
         o_q    <= '0;
      end
      else
      begin
         stage1 <= i_d;
         o_q    <= stage1;
      end
   end

endmodule

/* File: pkg/qdb_pkg.sv */
package qdb_pkg;

   // Bus and register geometry
   localparam int ADDR_W     = 16;
   localparam int SEL_W      = 3;
   localparam int BYTE_W     = 8;
   localparam int NUM_CH     = 4;
   localparam int CODE_W     = 10;
   localparam int HI_W       = 2;
   localparam int STAT_W     = 4;
   localparam int STAT_LSB   = 2;
   localparam int HI_CODE_LSB = 0;
   localparam int MV_W       = 14;
   localparam int NA_W       = 25;

   // Clock and read reply delay (least time, rounded up)
   localparam int CLK_NS         = 10;
   localparam int READ_DELAY_NS  = 50;
   localparam int READ_DELAY_CYC = (READ_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] READ_CYC = 4'(READ_DELAY_CYC);

   // Converter weighting: volts in mV, currents in nA
   localparam int VOLT_LSB_MV  = 10;
   localparam int CUR0_STEP_NA = 19550;
   localparam int CUR4_STEP_NA = 15640;
   localparam int CUR4_BASE_NA = 4000000;
   localparam int CMP_MARGIN_MV = 30;

   // Comparator pairs: status bit k is channel A[k] against channel B[k]
   localparam logic [3:0][1:0] CMP_A = {2'h3, 2'h3, 2'h2, 2'h1};
   localparam logic [3:0][1:0] CMP_B = {2'h2, 2'h0, 2'h1, 2'h0};

   typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ_WAIT, PH_READ_DONE} qdb_phase_e;

   // Backplane pins as seen by the module
   typedef struct packed {
      logic                addr_valid;
      logic                write_cycle;
      logic                read_cycle;
      logic [ADDR_W-1:0]   addr;
      logic [BYTE_W-1:0]   data;
   } qdb_bus_s;

   // Controls that the bus control module drives to every I/O module
   typedef struct packed {
      logic ident_select;
      logic output_zero_ctl;
      logic diag_status_enable;
   } qdb_ctl_s;

   typedef struct packed {
      logic                          av_prev;
      logic                          module_selected;
      logic [SEL_W-1:0]              reg_sel;
      qdb_phase_e                    phase;
      logic [3:0]                    cnt;
      logic [NUM_CH-1:0][HI_W-1:0]   hold;
      logic [NUM_CH-1:0][CODE_W-1:0] outreg;
      logic [NUM_CH-1:0][CODE_W-1:0] dac;
      logic [BYTE_W-1:0]             rdata;
      logic                          drive;
      logic                          reply;
      logic [STAT_W-1:0]             cmp;
   } qdb_state_s;

endpackage
